// ==== urx_defs.svh ====
// register offsets, field positions, reset values and sampling counts
`ifndef URX_DEFS_SVH
`define URX_DEFS_SVH
`define URX_CTRL_OFS      12'h000
`define URX_STAT_OFS      12'h004
`define URX_CTRL_DBL      0
`define URX_CTRL_FILT     1
`define URX_CTRL_CLO      2
`define URX_CTRL_CHI      4
`define URX_CTRL_PAR      5
`define URX_CTRL_RST      6'h0C
`define URX_STAT_BUSY     0
`define URX_STAT_FERR     1
`define URX_STAT_ADDR     2
`define URX_STAT_CNT_LO   8
`define URX_STAT_CNT_HI   15
`define URX_SPB_NORMAL    5'h10
`define URX_SPB_DOUBLE    5'h08
`define URX_MIN_CHAR      4'h5
`define URX_MAX_CODE      3'h4
`endif

// ==== urx_pkg.sv ====
// types of the asynchronous receive front end
package urx_pkg;
    typedef enum logic [1:0] {ST_HUNT, ST_START, ST_DATA, ST_STOP} urx_state_e;
    typedef struct packed {
        logic       parity_en;
        logic [2:0] char_code;
        logic       filter_en;
        logic       dbl;
    } urx_ctrl_s;
    typedef struct packed {
        logic       is_address;
        logic       frame_error;
        logic       parity_bit;
        logic [8:0] data;
    } urx_frame_s;
endpackage : urx_pkg

// ==== urx_async_rx.sv ====
// clock and data recovery of the asynchronous receiver with apb control
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`include "urx_defs.svh"

module urx_async_rx (
    input  wire logic               ref_clk,
    input  wire logic               rstn,
    input  wire logic               sample_tick,
    input  wire logic               serial_receive_line,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic                    frame_valid,
    output urx_pkg::urx_frame_s     frame_out
);

    // frame length in bits, data plus parity
    function automatic logic [3:0] frame_bits(input logic [2:0] code, input logic par);
        frame_bits = `URX_MIN_CHAR + {1'b0, code} + {3'h0, par};
    endfunction : frame_bits

    // clamp illegal character codes to nine bits
    function automatic logic [2:0] clamp_code(input logic [2:0] code);
        clamp_code = (code > `URX_MAX_CODE) ? `URX_MAX_CODE : code;
    endfunction : clamp_code

    urx_pkg::urx_state_e  state_q;
    urx_pkg::urx_state_e  state_d;
    urx_pkg::urx_ctrl_s   ctrl_q;
    urx_pkg::urx_frame_s  frame_q;
    logic                 rx_meta_q;
    logic                 rx_sync_q;
    logic                 prev_q;
    logic [4:0]           smp_q;
    logic [1:0]           votes_q;
    logic [3:0]           bc_q;
    logic [9:0]           shr_q;
    logic                 valid_q;
    logic [7:0]           cnt_q;
    logic [31:0]          prdata_q;
    logic                 pslverr_q;

    wire logic [2:0]      code_w;
    wire logic [4:0]      spb_w;
    wire logic [4:0]      first_w;
    wire logic [4:0]      last_w;
    wire logic            line_w;
    wire logic            in_centre_w;
    wire logic            at_last_w;
    wire logic            at_end_w;
    wire logic            maj_w;
    wire logic            falling_w;
    wire logic [3:0]      nbits_w;
    wire logic [8:0]      mask_w;
    wire logic            frame_addr_w;
    wire logic            keep_w;
    wire logic            setup_w;
    wire logic            access_w;
    wire logic            hit_ctrl_w;
    wire logic            hit_stat_w;
    wire logic            wr_ctrl_w;
    wire logic [31:0]     rd_mux_w;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
        end else begin
            rx_meta_q <= serial_receive_line;
            rx_sync_q <= rx_meta_q;
        end
    end

    assign line_w = rx_sync_q;
    assign code_w = clamp_code(ctrl_q.char_code);
    // samples per bit from speed select
    // double speed follows the select bit
    assign spb_w = ctrl_q.dbl ? `URX_SPB_DOUBLE : `URX_SPB_NORMAL;
    assign first_w = {1'b0, spb_w[4:1]};
    assign last_w = first_w + 5'h02;
    assign in_centre_w = (smp_q >= first_w) && (smp_q <= last_w);
    assign at_last_w = (smp_q == last_w);
    assign at_end_w = (smp_q == spb_w);
    assign maj_w = ({1'b0, votes_q} + {2'h0, line_w}) >= 3'h2;
    assign falling_w = prev_q && !line_w;
    // five to ten bits per frame
    assign nbits_w = frame_bits(code_w, ctrl_q.parity_en);
    assign mask_w = 9'h1FF >> (`URX_MAX_CODE - code_w);
    // ninth bit or first stop bit marks address
    assign frame_addr_w = (code_w == `URX_MAX_CODE) ? shr_q[8] : maj_w;
    // only the receive path is gated
    assign keep_w = !ctrl_q.filter_en || frame_addr_w;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            urx_pkg::ST_HUNT: begin
                if (falling_w) begin
                    state_d = urx_pkg::ST_START;
                end
            end
            urx_pkg::ST_START: begin
                if (at_last_w && maj_w) begin
                    state_d = urx_pkg::ST_HUNT;
                end else if (at_end_w) begin
                    state_d = urx_pkg::ST_DATA;
                end
            end
            urx_pkg::ST_DATA: begin
                if (at_end_w && (bc_q == nbits_w - 4'h1)) begin
                    state_d = urx_pkg::ST_STOP;
                end
            end
            urx_pkg::ST_STOP: begin
                // hunt right after last stop vote
                if (at_last_w) begin
                    state_d = urx_pkg::ST_HUNT;
                end
            end
        endcase
    end

    // state advances only on sample ticks
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_q <= urx_pkg::ST_HUNT;
            prev_q  <= 1'b1;
        end else if (sample_tick) begin
            state_q <= state_d;
            prev_q  <= line_w;
        end
    end

    // sample count restarts on every start edge
    // sample number steps 1..spb per bit
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            smp_q   <= 5'h00;
            votes_q <= 2'h0;
            bc_q    <= 4'h0;
        end else if (sample_tick) begin
            if (state_q == urx_pkg::ST_HUNT) begin
                // edge tick is sample one, next tick sample two
                smp_q   <= 5'h02;
                votes_q <= 2'h0;
                bc_q    <= 4'h0;
            end else if (at_end_w) begin
                smp_q   <= 5'h01;
                votes_q <= 2'h0;
                bc_q    <= (state_q == urx_pkg::ST_DATA) ? bc_q + 4'h1 : 4'h0;
            end else begin
                smp_q   <= smp_q + 5'h01;
                votes_q <= (in_centre_w && line_w) ? votes_q + 2'h1 : votes_q;
            end
        end
    end

    // store voted data and parity bits
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            shr_q <= 10'h000;
        end else if (sample_tick && (state_q == urx_pkg::ST_DATA) && at_last_w) begin
            shr_q[bc_q] <= maj_w;
        end
    end

    // frame ends at first stop bit vote
    // voted zero stop bit flags frame error
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            valid_q <= 1'b0;
            frame_q <= '0;
            cnt_q   <= 8'h00;
        end else begin
            valid_q <= 1'b0;
            if (sample_tick && (state_q == urx_pkg::ST_STOP) && at_last_w && keep_w) begin
                valid_q             <= 1'b1;
                frame_q.data        <= shr_q[8:0] & mask_w;
                frame_q.parity_bit  <= ctrl_q.parity_en & shr_q[nbits_w - 4'h1];
                frame_q.frame_error <= !maj_w;
                frame_q.is_address  <= frame_addr_w;
                cnt_q               <= cnt_q + 8'h01;
            end
        end
    end

    assign frame_valid = valid_q;
    assign frame_out = frame_q;

    // apb slave, zero wait state
    assign setup_w = psel && !penable;
    assign access_w = psel && penable;
    assign hit_ctrl_w = (paddr == `URX_CTRL_OFS);
    assign hit_stat_w = (paddr == `URX_STAT_OFS);
    assign wr_ctrl_w = access_w && pwrite && hit_ctrl_w;
    assign rd_mux_w = hit_ctrl_w ? {26'h0, ctrl_q} :
                      hit_stat_w ? {16'h0, cnt_q, 5'h00, frame_q.is_address,
                                    frame_q.frame_error, state_q != urx_pkg::ST_HUNT} :
                      32'h0000_0000;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl_q    <= `URX_CTRL_RST;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            if (wr_ctrl_w) begin
                ctrl_q <= pwdata[`URX_CTRL_PAR:`URX_CTRL_DBL];
            end
            if (setup_w) begin
                prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux_w;
                pslverr_q <= !(hit_ctrl_w || (hit_stat_w && !pwrite));
            end
        end
    end

    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    start_launch_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (sample_tick && state_q == urx_pkg::ST_HUNT && falling_w)
        |=> (state_q == urx_pkg::ST_START && smp_q == 5'h02))
        else $error("falling edge did not launch start");

    start_reject_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (sample_tick && state_q == urx_pkg::ST_START && at_last_w && maj_w)
        |=> state_q == urx_pkg::ST_HUNT)
        else $error("noisy start not rejected");

    start_window_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (sample_tick && state_q == urx_pkg::ST_START && !ctrl_q.dbl
         && (smp_q < 5'h0A) && state_d == urx_pkg::ST_HUNT) |-> 1'b0)
        else $error("start judged before sample ten");

    bit_wrap_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (sample_tick && state_q == urx_pkg::ST_DATA && !ctrl_q.dbl && smp_q == 5'h10)
        |=> smp_q == 5'h01)
        else $error("normal bit not sixteen samples");

    dbl_wrap_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (sample_tick && state_q != urx_pkg::ST_HUNT && ctrl_q.dbl && smp_q == 5'h08)
        |=> (smp_q == 5'h01 || state_q == urx_pkg::ST_HUNT))
        else $error("double speed bit not eight samples");

    early_start_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (sample_tick && state_q == urx_pkg::ST_STOP && at_last_w)
        |=> state_q == urx_pkg::ST_HUNT)
        else $error("not hunting after stop vote");

    frame_err_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (sample_tick && state_q == urx_pkg::ST_STOP && at_last_w && keep_w && votes_q == 2'h0)
        |=> (frame_valid && frame_out.frame_error))
        else $error("low stop bit without frame error");

    filter_drop_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        frame_valid && $past(ctrl_q.filter_en) |-> frame_out.is_address)
        else $error("data frame passed filter");

    valid_pulse_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        frame_valid |-> ($past(state_q) == urx_pkg::ST_STOP && !$past(frame_valid)))
        else $error("frame emitted outside stop bit");

    need_high_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (sample_tick && state_q == urx_pkg::ST_HUNT && !prev_q)
        |=> state_q == urx_pkg::ST_HUNT)
        else $error("start taken without high line");

    apb_err_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (setup_w && !hit_ctrl_w && !hit_stat_w) |=> (access_w |-> pslverr))
        else $error("unmapped access without error");

endmodule : urx_async_rx

// ==== urx_tx_model.sv ====
// behavioural remote serial transmitter driving the receive line
`timescale 1ns/1ps
module urx_tx_model (
    input  wire logic ref_clk,
    input  wire logic sample_tick,
    output logic      line
);
    initial line = 1'b1;
    task automatic send(input logic [9:0] bits, input int n, input int spb, input int stop_ticks,
                        input logic stop_v, input int glitch);
        int i;
        int k;
        for (i = -1; i <= n; i++) begin
            for (k = 0; k < ((i == n) ? stop_ticks : spb); k++) begin
                line <= (i < 0) ? 1'b0 : (i == n) ? stop_v : bits[i] ^ (i == 0 && k == glitch);
                @(posedge ref_clk iff sample_tick);
            end
        end
    endtask : send
    task automatic idle(input int ticks);
        line <= 1'b1;
        repeat (ticks) @(posedge ref_clk iff sample_tick);
    endtask : idle
endmodule : urx_tx_model

// ==== uart_async_rx_recovery_bench.sv ====
// self-checking bench of the asynchronous receive front end
`timescale 1ns/1ps
`include "urx_defs.svh"
module uart_async_rx_recovery_bench;
    logic                ref_clk, rstn, sample_tick;
    logic                psel, penable, pwrite;
    logic [11:0]         paddr;
    logic [31:0]         pwdata, prdata, r, seed = 32'h0000_003E;
    logic                pready, pslverr, frame_valid, line, e;
    logic [1:0]          tick_cnt = 2'h0;
    urx_pkg::urx_frame_s frame_out, last_f;
    urx_pkg::urx_frame_s exp_q[$];
    int                  fail_count = 0, compares = 0, delivered = 0, spb;

    urx_async_rx dut_u (.ref_clk(ref_clk), .rstn(rstn), .sample_tick(sample_tick),
        .serial_receive_line(line), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_valid(frame_valid), .frame_out(frame_out));
    urx_tx_model tx_u (.ref_clk(ref_clk), .sample_tick(sample_tick), .line(line));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        tick_cnt    <= tick_cnt + 2'h1;
        sample_tick <= (tick_cnt == 2'h3);
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic report_and_stop();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        if (!w) r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    // reference frame from sent bits, dropped when filtered
    task automatic frame(input logic [9:0] raw, input int chars, input logic par, input int stop_ticks,
                         input logic stop_v, input int glitch, input logic filt);
        urx_pkg::urx_frame_s f;
        f.data        = raw[8:0] & ~(9'h1FF << chars);
        f.parity_bit  = par & raw[chars];
        f.frame_error = ~stop_v;
        f.is_address  = (chars == 9) ? raw[8] : stop_v;
        if (!(filt && !f.is_address)) begin
            exp_q.push_back(f);
            delivered++;
            last_f = f;
        end
        tx_u.send(raw, chars + par, spb, stop_ticks, stop_v, glitch);
    endtask : frame

    always @(posedge ref_clk) begin
        if (frame_valid === 1'b1) begin
            if (exp_q.size() == 0) chk({20'h0, frame_out}, 32'hFFFF_FFFF);
            else chk({20'h0, frame_out}, {20'h0, exp_q.pop_front()});
        end
    end

    initial begin
        #400000;
        fail_count++;
        report_and_stop();
    end

    initial begin
        rstn    <= 1'b0;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwrite  <= 1'b0;
        paddr   <= 12'h000;
        pwdata  <= 32'h0000_0000;
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        apb(1'b0, `URX_CTRL_OFS, 32'h0000_0000);
        chk(r, 32'h0000_000C);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk({r[30:0], e}, 32'h0000_0001);
        apb(1'b1, `URX_STAT_OFS, 32'hFFFF_FFFF);
        chk({31'h0, e}, 32'h0000_0001);
        for (int dbl = 0; dbl < 2; dbl++) begin
            for (int par = 0; par < 2; par++) begin
                for (int code = 0; code < 5; code++) begin
                    spb = dbl ? 8 : 16;
                    apb(1'b1, `URX_CTRL_OFS, {26'h0, par[0], code[2:0], 1'b0, dbl[0]});
                    tx_u.idle(2);
                    r = xs();
                    frame(r[9:0], code + 5, par[0], (code == 4) ? spb / 2 + 2 : spb, 1'b1,
                          (code % 2 == 0) ? spb / 2 : -1, 1'b0);
                    // next start right after last stop vote
                    if (code == 4) frame(r[19:10], 9, par[0], spb, 1'b1, -1, 1'b0);
                end
            end
        end
        spb = 16;
        apb(1'b1, `URX_CTRL_OFS, 32'h0000_000C);
        tx_u.idle(2);
        // low stop bit gives frame error
        frame(r[9:0], 8, 1'b0, spb, 1'b0, -1, 1'b0);
        tx_u.idle(20);
        apb(1'b1, `URX_CTRL_OFS, 32'h0000_0012);
        tx_u.idle(2);
        frame({2'b00, r[7:0]}, 9, 1'b0, spb, 1'b1, -1, 1'b1);
        frame({2'b01, r[7:0]}, 9, 1'b0, spb, 1'b1, -1, 1'b1);
        apb(1'b1, `URX_CTRL_OFS, 32'h0000_000E);
        tx_u.idle(2);
        frame(r[9:0], 8, 1'b0, spb, 1'b0, -1, 1'b1);
        tx_u.idle(20);
        frame(r[9:0], 8, 1'b0, spb, 1'b1, -1, 1'b1);
        // illegal code acts as nine bits
        apb(1'b1, `URX_CTRL_OFS, 32'h0000_001C);
        tx_u.idle(2);
        r = xs();
        frame(r[9:0], 9, 1'b0, spb, 1'b1, -1, 1'b0);
        // spikes rejected at the vote boundary
        for (int dbl = 0; dbl < 2; dbl++) begin
            spb = dbl ? 8 : 16;
            apb(1'b1, `URX_CTRL_OFS, {30'h3, 1'b0, dbl[0]});
            tx_u.idle(2);
            tx_u.send(10'h000, 0, spb / 2, 0, 1'b1, -1);
            tx_u.idle(3 * spb);
        end
        apb(1'b0, `URX_STAT_OFS, 32'h0000_0000);
        chk(r, {16'h0, delivered[7:0], 5'h0, last_f.is_address, last_f.frame_error, 1'b0});
        chk(exp_q.size(), 32'h0000_0000);
        report_and_stop();
    end
endmodule : uart_async_rx_recovery_bench
